// [logic/pdc_channel.sv]
// dma channel pair with ahb master port and read-path fifo
`timescale 1ns/1ps
`include "pdc_params.svh"
module pdc_fifo #(
	parameter int WIDTH = `PDC_FIFO_W,
	parameter int DEPTH = `PDC_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [CW-1:0] count_reg, count_next;
	logic push, pop;

	// pointer wrap for any depth
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// handshakes and flags
	assign o_in_ready = (count_reg != CW'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data = mem[rptr_reg];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// next pointers and fill level
	always_comb begin
		wptr_next = push ? bump(wptr_reg) : wptr_reg;
		rptr_next = pop ? bump(rptr_reg) : rptr_reg;
		count_next = count_reg;
		if (push & ~pop) begin
			count_next = count_reg + CW'(1);
		end else if (pop & ~push) begin
			count_next = count_reg - CW'(1);
		end
	end

	// state registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			count_reg <= count_next;
		end
	end

	// storage, no reset needed
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wptr_reg] <= i_in_data;
		end
	end
endmodule

module pdc_channel import pdc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_rd_start,
	input wire pdc_cfg_t i_rd_cfg,
	output logic [7:0] o_rd_byte,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [`PDC_CNT_W-1:0] o_rd_transferred_byte_count,
	output logic o_rd_busy,
	output logic o_rd_done,
	output logic o_rd_fault,
	input wire logic i_wr_start,
	input wire pdc_cfg_t i_wr_cfg,
	input wire logic i_wr_valid,
	input wire logic [7:0] i_wr_byte,
	input wire logic i_wr_last,
	output logic o_wr_ready,
	output logic [`PDC_CNT_W-1:0] o_wr_transferred_byte_count,
	output logic o_wr_busy,
	output logic o_wr_done,
	output logic o_wr_fault,
	output pdc_ahb_req_t o_ahb,
	input wire logic [31:0] i_hrdata,
	input wire logic i_hready,
	input wire logic i_hresp
);
	pdc_state_t state_reg, state_next;
	pdc_ahb_req_t ahb_reg, ahb_next;
	pdc_cfg_t rd_cfg_reg, rd_cfg_next, wr_cfg_reg, wr_cfg_next;
	logic [`PDC_CNT_W-1:0] rd_cnt_reg, rd_cnt_next, wr_cnt_reg, wr_cnt_next;
	logic rd_busy_reg, rd_busy_next, wr_busy_reg, wr_busy_next;
	logic sel_wr_reg, sel_wr_next;
	logic hold_reg, hold_next, end_reg, end_next;
	logic [7:0] hold_byte_reg, hold_byte_next;
	logic wr_ready_reg, wr_ready_next;
	logic rd_done_reg, rd_done_next, wr_done_reg, wr_done_next;
	logic rd_fault_reg, rd_fault_next, wr_fault_reg, wr_fault_next;
	logic fifo_push, fifo_space, fifo_out_valid;
	logic [7:0] fifo_in, fifo_out;
	logic rd_want, rd_fin, wr_fin;

	// byte lane of a 32-bit word chosen by the low address bits
	function automatic logic [7:0] lane(input logic [31:0] w,
		input logic [1:0] a);
		lane = w[8*a +: 8];
	endfunction

	// read path buffer toward the peripheral
	pdc_fifo #(.WIDTH(8), .DEPTH(`PDC_FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_in_valid(fifo_push),
		.i_in_data(fifo_in),
		.o_in_ready(fifo_space),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out),
		.i_out_ready(i_rd_ready)
	);

	// fifo fills only on a completed, error-free read beat
	assign fifo_push = state_reg[2] & ~sel_wr_reg & i_hready & ~i_hresp;
	assign fifo_in = lane(i_hrdata, ahb_reg.haddr[1:0]);

	// channel progress terms
	assign rd_want = rd_busy_reg & (rd_cnt_reg != rd_cfg_reg.max_byte_count)
		& fifo_space; // [R4] [R11]
	assign rd_fin = rd_busy_reg & (rd_cnt_reg == rd_cfg_reg.max_byte_count);
	assign wr_fin = wr_busy_reg & ~hold_reg
		& (end_reg | wr_cnt_reg == wr_cfg_reg.max_byte_count); // [R5] [R8]

	// next state of both channels and the bus master
	always_comb begin
		state_next = state_reg;
		ahb_next = ahb_reg;
		rd_cfg_next = rd_cfg_reg;
		wr_cfg_next = wr_cfg_reg;
		rd_cnt_next = rd_cnt_reg;
		wr_cnt_next = wr_cnt_reg;
		rd_busy_next = rd_busy_reg;
		wr_busy_next = wr_busy_reg;
		sel_wr_next = sel_wr_reg;
		hold_next = hold_reg;
		end_next = end_reg;
		hold_byte_next = hold_byte_reg;
		rd_done_next = 1'b0;
		wr_done_next = 1'b0;
		rd_fault_next = 1'b0;
		wr_fault_next = 1'b0;
		// start captures its config; ignored while busy [R3] [R12] [R9]
		if (i_rd_start & ~rd_busy_reg) begin
			rd_cfg_next = i_rd_cfg;
			rd_cnt_next = '0;
			rd_busy_next = 1'b1;
		end
		if (i_wr_start & ~wr_busy_reg) begin
			wr_cfg_next = i_wr_cfg;
			wr_cnt_next = '0;
			wr_busy_next = 1'b1;
			end_next = 1'b0;
		end
		// take a byte from the peripheral; last marks a short transfer
		if (wr_ready_reg & i_wr_valid) begin
			hold_next = 1'b1;
			hold_byte_next = i_wr_byte;
			end_next = i_wr_last;
		end
		// completion once every byte has moved [R8]
		if (state_reg[0] & rd_fin) begin
			rd_busy_next = 1'b0;
			rd_done_next = 1'b1;
		end
		if (state_reg[0] & wr_fin) begin
			wr_busy_next = 1'b0;
			wr_done_next = 1'b1;
		end
		case (state_reg)
			PDC_IDLE: begin
				// one byte per beat at any byte address [R1] [R2] [R6]
				if (rd_want) begin
					sel_wr_next = 1'b0;
					ahb_next.haddr = rd_cfg_reg.buffer_start_pointer
						+ `PDC_ADDR_W'(rd_cnt_reg);
					ahb_next.hwrite = 1'b0;
					ahb_next.htrans = `PDC_HTRANS_NONSEQ;
					ahb_next.hsize = `PDC_HSIZE_BYTE;
					state_next = PDC_ADDR;
				end else if (wr_busy_reg & hold_reg) begin
					sel_wr_next = 1'b1;
					ahb_next.haddr = wr_cfg_reg.buffer_start_pointer
						+ `PDC_ADDR_W'(wr_cnt_reg);
					ahb_next.hwrite = 1'b1;
					ahb_next.htrans = `PDC_HTRANS_NONSEQ;
					ahb_next.hsize = `PDC_HSIZE_BYTE;
					state_next = PDC_ADDR;
				end
			end
			PDC_ADDR: begin
				// hold the address phase until the slave is ready [R11]
				if (i_hready) begin
					ahb_next.htrans = `PDC_HTRANS_IDLE;
					ahb_next.hwdata = {4{hold_byte_reg}};
					state_next = PDC_DATA;
				end
			end
			PDC_DATA: begin
				if (i_hready) begin
					state_next = PDC_IDLE;
					if (i_hresp) begin
						// unchecked pointer hit an error: abort [R10]
						if (sel_wr_reg) begin
							wr_busy_next = 1'b0;
							hold_next = 1'b0;
							wr_fault_next = 1'b1;
							wr_done_next = 1'b1;
						end else begin
							rd_busy_next = 1'b0;
							rd_fault_next = 1'b1;
							rd_done_next = 1'b1;
						end
					end else if (sel_wr_reg) begin
						wr_cnt_next = wr_cnt_reg + `PDC_CNT_W'(1);
						hold_next = 1'b0;
					end else begin
						rd_cnt_next = rd_cnt_reg + `PDC_CNT_W'(1);
					end
				end
			end
			default: begin
				state_next = PDC_IDLE;
				ahb_next.htrans = `PDC_HTRANS_IDLE;
			end
		endcase
		// ask for a byte only while room remains under the max [R5]
		wr_ready_next = wr_busy_next & ~hold_next & ~end_next
			& ~(wr_ready_reg & i_wr_valid)
			& (wr_cnt_next != wr_cfg_next.max_byte_count);
	end

	// state registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= PDC_IDLE;
			ahb_reg <= '0;
			rd_cfg_reg <= '0;
			wr_cfg_reg <= '0;
			rd_cnt_reg <= '0;
			wr_cnt_reg <= '0;
			rd_busy_reg <= 1'b0;
			wr_busy_reg <= 1'b0;
			sel_wr_reg <= 1'b0;
			hold_reg <= 1'b0;
			end_reg <= 1'b0;
			hold_byte_reg <= '0;
			wr_ready_reg <= 1'b0;
			rd_done_reg <= 1'b0;
			wr_done_reg <= 1'b0;
			rd_fault_reg <= 1'b0;
			wr_fault_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ahb_reg <= ahb_next;
			rd_cfg_reg <= rd_cfg_next;
			wr_cfg_reg <= wr_cfg_next;
			rd_cnt_reg <= rd_cnt_next;
			wr_cnt_reg <= wr_cnt_next;
			rd_busy_reg <= rd_busy_next;
			wr_busy_reg <= wr_busy_next;
			sel_wr_reg <= sel_wr_next;
			hold_reg <= hold_next;
			end_reg <= end_next;
			hold_byte_reg <= hold_byte_next;
			wr_ready_reg <= wr_ready_next;
			rd_done_reg <= rd_done_next;
			wr_done_reg <= wr_done_next;
			rd_fault_reg <= rd_fault_next;
			wr_fault_reg <= wr_fault_next;
		end
	end

	// outputs, fifo head is a registered array entry
	assign o_ahb = ahb_reg;
	assign o_rd_byte = fifo_out;
	assign o_rd_valid = fifo_out_valid;
	assign o_rd_transferred_byte_count = rd_cnt_reg;
	assign o_rd_busy = rd_busy_reg;
	assign o_rd_done = rd_done_reg;
	assign o_rd_fault = rd_fault_reg;
	assign o_wr_ready = wr_ready_reg;
	assign o_wr_transferred_byte_count = wr_cnt_reg;
	assign o_wr_busy = wr_busy_reg;
	assign o_wr_done = wr_done_reg;
	assign o_wr_fault = wr_fault_reg;
endmodule

// [logic/pdc_params.svh]
// constants for the peripheral dma channel
// Summary of operation
// R1: each channel is a bus master on the ahb interconnect, like the processor; here both share one master port, read first.
// R2: the channel reaches data ram only, never flash.
// R3: a peripheral holds independent channels, here one read and one write.
// R4: on start the read channel fetches max_byte_count bytes from its pointer.
// R5: the write channel stores bytes from its pointer, never beyond the max.
// R6: pointers are byte addresses, buffers are packed with no alignment.
// R7: software keeps the write max no larger than the reserved buffer.
// R8: after a transfer the moved byte count is readable, maybe under the max.
// R9: software loads a valid ram pointer before any start.
// R10: the pointer is not checked; a bad address may fault or corrupt ram.
// R11: under bus contention the channel stalls until access is granted.
// R12: pointer and max are captured at start so software may reload them.
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH
`define PDC_ADDR_W 32
`define PDC_CNT_W 16
`define PDC_FIFO_W 8
`define PDC_FIFO_DEPTH 4
`define PDC_HTRANS_IDLE 2'h0
`define PDC_HTRANS_NONSEQ 2'h2
`define PDC_HSIZE_BYTE 3'h0
`endif

// [logic/pdc_pkg.sv]
// types for the peripheral dma channel
`include "pdc_params.svh"
package pdc_pkg;
	typedef struct packed {
		logic [`PDC_ADDR_W-1:0] buffer_start_pointer;
		logic [`PDC_CNT_W-1:0] max_byte_count;
	} pdc_cfg_t;
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
	} pdc_ahb_req_t;
	typedef enum logic [2:0] {
		PDC_IDLE = 3'b001,
		PDC_ADDR = 3'b010,
		PDC_DATA = 3'b100
	} pdc_state_t;
endpackage

// [sim/pdc_channel_assertions.sv]
// port assertions for the dma channel pair
`timescale 1ns/1ps
module pdc_channel_assertions import pdc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_rd_start,
	input wire pdc_cfg_t i_rd_cfg,
	input wire logic [15:0] o_rd_transferred_byte_count,
	input wire logic o_rd_busy,
	input wire logic o_rd_done,
	input wire logic o_rd_fault,
	input wire logic i_wr_start,
	input wire pdc_cfg_t i_wr_cfg,
	input wire logic [15:0] o_wr_transferred_byte_count,
	input wire logic o_wr_busy,
	input wire logic o_wr_done,
	input wire logic o_wr_fault,
	input wire pdc_ahb_req_t o_ahb,
	input wire logic i_hready,
	input wire logic i_hresp
);
	logic [15:0] rcap;
	logic [15:0] wcap;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence rd_go;
		i_rd_start && !o_rd_busy;
	endsequence
	sequence wr_go;
		i_wr_start && !o_wr_busy;
	endsequence
	sequence rd_err;
		i_hresp && i_hready && o_rd_busy && !o_wr_busy;
	endsequence
	// maximum captured at each accepted start
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rcap <= '0;
			wcap <= '0;
		end else begin
			if (i_rd_start && !o_rd_busy) rcap <= i_rd_cfg.max_byte_count;
			if (i_wr_start && !o_wr_busy) wcap <= i_wr_cfg.max_byte_count;
		end
	end
	rd_start_a: assert property (rd_go |=> o_rd_busy && o_rd_transferred_byte_count == 0)
		else $error("read start lost");
	wr_start_a: assert property (wr_go |=> o_wr_busy && o_wr_transferred_byte_count == 0)
		else $error("write start lost");
	rd_bound_a: assert property (o_rd_transferred_byte_count <= rcap)
		else $error("read count over max");
	wr_bound_a: assert property (o_wr_transferred_byte_count <= wcap)
		else $error("write count over max");
	byte_beat_a: assert property (o_ahb.htrans == 2'h2 |-> o_ahb.hsize == 0)
		else $error("beat not byte sized");
	addr_hold_a: assert property (o_ahb.htrans == 2'h2 && !i_hready
		|=> o_ahb.htrans == 2'h2 && $stable(o_ahb.haddr))
		else $error("address dropped in stall");
	rd_abort_a: assert property (rd_err |-> ##[1:2] o_rd_done && o_rd_fault)
		else $error("bus error not ending read");
	idle_bus_a: assert property (!o_rd_busy && !o_wr_busy |-> o_ahb.htrans == 0)
		else $error("bus request while idle");
endmodule
bind pdc_channel pdc_channel_assertions chk (.*);

// [sim/pdc_ram_model.sv]
// ahb slave model of the data ram
`timescale 1ns/1ps
module pdc_ram_model import pdc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire pdc_ahb_req_t i_ahb,
	output logic [31:0] o_hrdata,
	output logic o_hready,
	output logic o_hresp
);
	logic [7:0] mem [0:255];
	logic [31:0] a;
	logic ph, w, bad, slow;
	assign bad = i_ahb.haddr[31:8] != 24'h200000; // faults off ram
	initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
	// one beat at a time with random waits
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			{ph, o_hresp, o_hrdata} <= '0;
			o_hready <= 1;
		end else begin
			o_hrdata <= ~o_hrdata;
			slow = $urandom % 3 == 0;
			if (ph && o_hready) begin
				ph <= 0;
				o_hresp <= 0;
				if (w && !o_hresp) mem[a[7:0]] <= i_ahb.hwdata[8*a[1:0]+:8];
			end else if (ph) begin
				o_hready <= 1;
				o_hrdata[8*a[1:0]+:8] <= mem[a[7:0]];
			end else if (o_hready && i_ahb.htrans == 2'h2) begin
				a <= i_ahb.haddr;
				w <= i_ahb.hwrite;
				ph <= 1;
				o_hresp <= bad;
				o_hready <= !(bad || slow);
				o_hrdata[8*i_ahb.haddr[1:0]+:8] <= mem[i_ahb.haddr[7:0]];
			end else begin
				// contention holds off the next address phase
				o_hready <= !slow;
			end
		end
	end
endmodule

// [sim/tb_peripheral_dma_channel.sv]
// self-checking bench for the dma channel pair
`timescale 1ns/1ps
`define CHK(n,e,s) begin check_count++; if ((s) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_peripheral_dma_channel;
	import pdc_pkg::*;
	logic i_clk = 0, i_arst_n = 0, rs = 0, ws = 0, rr = 0, wv = 0, wl = 0;
	logic [7:0] wb = 0, rb;
	pdc_cfg_t rc = '0, wc = '0;
	logic rv, rbz, rd, rf, wrdy, wbz, wd, wf, hr, he;
	logic [15:0] ra, wa;
	logic [31:0] hrd, p1, p2;
	logic [15:0] m1, m2;
	int n2, s1;
	pdc_ahb_req_t ahb;
	int n_fail = 0, check_count = 0;
	always #20 i_clk = ~i_clk;
	pdc_channel dut (.i_clk, .i_arst_n, .i_rd_start(rs), .i_rd_cfg(rc),
		.o_rd_byte(rb), .o_rd_valid(rv), .i_rd_ready(rr), .o_rd_transferred_byte_count(ra),
		.o_rd_busy(rbz), .o_rd_done(rd), .o_rd_fault(rf), .i_wr_start(ws),
		.i_wr_cfg(wc), .i_wr_valid(wv), .i_wr_byte(wb), .i_wr_last(wl),
		.o_wr_ready(wrdy), .o_wr_transferred_byte_count(wa), .o_wr_busy(wbz), .o_wr_done(wd),
		.o_wr_fault(wf), .o_ahb(ahb), .i_hrdata(hrd), .i_hready(hr),
		.i_hresp(he));
	pdc_ram_model ram (.i_clk, .i_arst_n, .i_ahb(ahb), .o_hrdata(hrd),
		.o_hready(hr), .o_hresp(he));
	task automatic test_done;
		if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// initial ram contents at a byte address
	function automatic logic [7:0] ram_val(input logic [7:0] a);
		ram_val = a ^ 8'hA5;
	endfunction
	// read run, config scrambled after start
	task automatic rd_run(input logic [31:0] p, input logic [15:0] m,
		input int st, input bit hold, input bit bad);
		int got;
		bit dn, fl;
		got = 0;
		dn = 0;
		fl = 0;
		@(negedge i_clk) rc = {p, m};
		rs = 1;
		@(negedge i_clk) rs = 0;
		rc = ~rc;
		if (hold) begin
			repeat (60) @(negedge i_clk);
			`CHK("fifo fill", (m < 4) ? m : 16'h4, ra)
		end
		repeat (3000) begin
			@(negedge i_clk);
			fl |= rf;
			if (rd) dn = 1;
			if (dn && !rv) break;
			rr = ($urandom % 4) >= st;
			if (rv && rr) begin
				`CHK("rd byte", ram_val(p[7:0] + got[7:0]), rb)
				got++;
			end
		end
		rr = 0;
		`CHK("rd done", 1'b1, dn)
		`CHK("rd count", bad ? 0 : int'(m), got)
		`CHK("rd transferred_byte_count", bad ? 16'h0 : m, ra)
		`CHK("rd fault", bad, fl)
	endtask
	// write run, stream may end early with last
	task automatic wr_run(input logic [31:0] p, input logic [15:0] m,
		input int n, input bit bad);
		logic [7:0] q [$];
		int sent, e;
		bit fl, dn, tk;
		sent = 0;
		fl = 0;
		dn = 0;
		tk = 0;
		e = bad ? 0 : (n < m ? n : m);
		@(negedge i_clk) wc = {p, m};
		ws = 1;
		@(negedge i_clk) ws = 0;
		wc = ~wc;
		repeat (3000) begin
			@(negedge i_clk);
			fl |= wf;
			if (wd) begin
				dn = 1;
				break;
			end
			// an offer stands until the channel takes it
			if (!wv || tk) begin
				wv = (sent < n) && ($urandom % 2);
				wb = 8'($urandom);
				wl = wv && (sent == n - 1);
			end
			tk = wv && wrdy;
			if (tk) begin
				q.push_back(wb);
				sent++;
			end
		end
		wv = 0;
		wl = 0;
		`CHK("wr done", 1'b1, dn)
		`CHK("wr transferred_byte_count", e[15:0], wa)
		`CHK("wr fault", bad, fl)
		for (int i = 0; i <= e; i++) begin
			if (i < e) `CHK("ram byte", q[i], ram.mem[p[7:0] + i])
			else `CHK("ram guard", ram_val(p[7:0] + i[7:0]), ram.mem[p[7:0] + i])
			ram.mem[p[7:0] + i] = ram_val(p[7:0] + i[7:0]);
		end
	endtask
	// main sequence: fifo fill, random pairs, faults
	initial begin
		void'($urandom(32'h6C946570));
		repeat (5) @(negedge i_clk);
		i_arst_n = 1;
		rd_run(32'h20000003, 16'h8, 0, 1, 0);
		for (int k = 0; k < 12; k++) begin
			p1 = 32'h20000000 + $urandom % 100; // valid ram pointer
			p2 = 32'h20000080 + $urandom % 100; // valid ram pointer
			m1 = 16'($urandom % 10);
			m2 = 16'($urandom % 10); // max fits the reserved buffer
			s1 = $urandom % 4;
			n2 = 1 + $urandom % 12;
			fork
				rd_run(p1, m1, s1, 0, 0);
				wr_run(p2, m2, n2, 0);
			join
		end
		rd_run(32'h00001000, 16'h4, 0, 0, 1);
		wr_run(32'h00002001, 16'h3, 3, 1);
		test_done;
	end
	// watchdog
	initial begin
		repeat (60000) @(posedge i_clk);
		n_fail++;
		test_done;
	end
endmodule
